/* File: hw/crvt_top.sv */
// vertical timing, cursor location and double-buffered start address
`timescale 1ns/1ps
module crvt_top (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] io_addr_in,
  input  wire logic        io_wr_in,
  input  wire logic        io_rd_in,
  input  wire logic [7:0]  io_wdata_in,
  input  wire logic        line_tick_in,
  input  wire logic        frame_start_in,
  input  wire logic        text_mode_in,
  output logic      [7:0]  io_rdata_out,
  output logic             vsync_out,
  output logic             vdisp_en_out,
  output logic      [crvt_pkg::CRVT_START_W-1:0] start_addr_out,
  output logic      [15:0] cursor_addr_out,
  output logic             cursor_en_out,
  output logic             ext_mode_out
);
  import crvt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0]             crtc_index;
  logic [7:0]             ext_index;
  logic [7:0]             vertical_overflow;
  logic [7:0]             display_start_high;
  logic [7:0]             display_start_low;
  logic [7:0]             cursor_location_high;
  logic [7:0]             cursor_location_low;
  logic [7:0]             vsync_start_low;
  logic [7:0]             vsync_end_and_irq_ctl;
  logic [7:0]             vdisplay_end_low;
  logic [7:0]             row_pitch_low;
  logic [7:0]             vdisplay_end_extension;
  logic [7:0]             vsync_start_extension;
  logic [7:0]             display_start_extension;
  logic [7:0]             io_control;
  logic                   start_update;
  logic                   irq_pending;
  logic [CRVT_LINE_W-1:0] line_cnt;
  crvt_sync_t             sync_state;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  wire crtc_idx_hit = (io_addr_in == CRVT_IO_CRTC_IDX_MONO) ||
                      (io_addr_in == CRVT_IO_CRTC_IDX_COLOR);
  wire crtc_dat_hit = (io_addr_in == CRVT_IO_CRTC_DAT_MONO) ||
                      (io_addr_in == CRVT_IO_CRTC_DAT_COLOR);
  wire ext_idx_hit  = (io_addr_in == CRVT_IO_EXT_IDX);
  wire ext_dat_hit  = (io_addr_in == CRVT_IO_EXT_DAT);
  wire status_hit   = (io_addr_in == CRVT_IO_STATUS_ZERO);

  wire crtc_wr      = io_wr_in && crtc_dat_hit;
  wire ext_wr       = io_wr_in && ext_dat_hit;

  wire ext_mode     = io_control[CRVT_BIT_MODE_EXT];

  wire wr_locked    = vsync_end_and_irq_ctl[CRVT_BIT_PROTECT] &&
                      (crtc_index <= CRVT_IDX_PROTECT_LAST);

  wire wr_ovf       = crtc_wr && (crtc_index == CRVT_IDX_VERTICAL_OVERFLOW);
  wire wr_sa_high   = crtc_wr && (crtc_index == CRVT_IDX_DISPLAY_START_HIGH);
  wire wr_sa_low    = crtc_wr && (crtc_index == CRVT_IDX_DISPLAY_START_LOW);
  wire wr_cur_high  = crtc_wr && (crtc_index == CRVT_IDX_CURSOR_LOCATION_HI);
  wire wr_cur_low   = crtc_wr && (crtc_index == CRVT_IDX_CURSOR_LOCATION_LO);
  wire wr_vss_low   = crtc_wr && (crtc_index == CRVT_IDX_VSYNC_START_LOW);
  wire wr_vse       = crtc_wr && (crtc_index == CRVT_IDX_VSYNC_END_IRQ_CTL);
  wire wr_vde_low   = crtc_wr && (crtc_index == CRVT_IDX_VDISPLAY_END_LOW);
  wire wr_pitch     = crtc_wr && (crtc_index == CRVT_IDX_ROW_PITCH_LOW);
  wire wr_vde_ext   = crtc_wr && (crtc_index == CRVT_IDX_VDISPLAY_END_EXT);
  wire wr_vss_ext   = crtc_wr && (crtc_index == CRVT_IDX_VSYNC_START_EXT);
  wire wr_sa_ext    = crtc_wr && (crtc_index == CRVT_IDX_DISPLAY_START_EXT);
  wire wr_ioctl     = ext_wr && (ext_index == CRVT_IDX_IO_CONTROL);

  ////////////////////////////////////////////////////////////////////////////////
  // overflow write, protected except its bit 4
  logic [7:0] next_vertical_overflow;
  assign next_vertical_overflow = wr_locked ?
      {vertical_overflow[7:5], io_wdata_in[CRVT_BIT_OVF_ALWAYS_WR], vertical_overflow[3:0]} :
      io_wdata_in;

  logic [7:0] next_vsync_end;
  assign next_vsync_end = {io_wdata_in[7], vsync_end_and_irq_ctl[CRVT_BIT_RESERVED],
                           io_wdata_in[5:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      crtc_index              <= CRVT_RST_BYTE;
      ext_index               <= CRVT_RST_BYTE;
      vertical_overflow       <= CRVT_RST_BYTE;
      display_start_high      <= CRVT_RST_BYTE;
      display_start_low       <= CRVT_RST_BYTE;
      cursor_location_high    <= CRVT_RST_BYTE;
      cursor_location_low     <= CRVT_RST_BYTE;
      vsync_start_low         <= CRVT_RST_BYTE;
      vsync_end_and_irq_ctl   <= CRVT_RST_BYTE;
      vdisplay_end_low        <= CRVT_RST_BYTE;
      row_pitch_low           <= CRVT_RST_BYTE;
      vdisplay_end_extension  <= CRVT_RST_BYTE;
      vsync_start_extension   <= CRVT_RST_BYTE;
      display_start_extension <= CRVT_RST_BYTE;
      io_control              <= CRVT_RST_BYTE;
    end else begin
      if (io_wr_in && crtc_idx_hit) begin
        crtc_index <= io_wdata_in;
      end
      if (io_wr_in && ext_idx_hit) begin
        ext_index <= io_wdata_in;
      end
      if (wr_ovf) begin
        vertical_overflow <= next_vertical_overflow;
      end
      if (wr_sa_high) begin
        display_start_high <= io_wdata_in;
      end
      if (wr_sa_low) begin
        display_start_low <= io_wdata_in;
      end
      if (wr_cur_high) begin
        cursor_location_high <= io_wdata_in;
      end
      if (wr_cur_low) begin
        cursor_location_low <= io_wdata_in;
      end
      if (wr_vss_low) begin
        vsync_start_low <= io_wdata_in;
      end
      if (wr_vse) begin
        vsync_end_and_irq_ctl <= next_vsync_end;
      end
      if (wr_vde_low) begin
        vdisplay_end_low <= io_wdata_in;
      end
      if (wr_pitch) begin
        row_pitch_low <= io_wdata_in;
      end
      if (wr_vde_ext) begin
        vdisplay_end_extension <= io_wdata_in;
      end
      if (wr_vss_ext) begin
        vsync_start_extension <= io_wdata_in;
      end
      if (wr_sa_ext) begin
        display_start_extension <= io_wdata_in;
      end
      if (wr_ioctl) begin
        io_control <= io_wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // vertical values
  logic [CRVT_LINE_W-1:0] vss_value;
  logic [CRVT_LINE_W-1:0] vde_value;

  crvt_vsel u_vss_sel (
    .ext_mode_in (ext_mode),
    .low_in      (vsync_start_low),
    .ext_in      (vsync_start_extension[3:0]),
    .ovf_hi_in   (vertical_overflow[CRVT_BIT_OVF_VSS9]),
    .ovf_lo_in   (vertical_overflow[CRVT_BIT_OVF_VSS8]),
    .value_out   (vss_value)
  );

  crvt_vsel u_vde_sel (
    .ext_mode_in (ext_mode),
    .low_in      (vdisplay_end_low),
    .ext_in      (vdisplay_end_extension[3:0]),
    .ovf_hi_in   (vertical_overflow[CRVT_BIT_OVF_VDE9]),
    .ovf_lo_in   (vertical_overflow[CRVT_BIT_OVF_VDE8]),
    .value_out   (vde_value)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // scan-line counter, line 0 is the first active line
  wire [CRVT_LINE_W-1:0] next_line = frame_start_in ? CRVT_RST_LINE :
                                     CRVT_LINE_W'(line_cnt + 1'b1);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      line_cnt <= CRVT_RST_LINE;
    end else if (frame_start_in || line_tick_in) begin
      line_cnt <= next_line;
    end
  end

  wire sync_begin = line_tick_in && !frame_start_in && (next_line == vss_value);
  wire sync_end   = line_tick_in && !frame_start_in &&
                    (next_line[3:0] == vsync_end_and_irq_ctl[3:0]);

  // a frame restart mid-pulse keeps the pulse; only the end value stops it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_state <= CRVT_SYNC_IDLE;
    end else begin
      case (sync_state)
        CRVT_SYNC_IDLE: begin
          if (sync_begin) begin
            sync_state <= CRVT_SYNC_ON;
          end
        end
        CRVT_SYNC_ON: begin
          if (sync_end) begin
            sync_state <= CRVT_SYNC_IDLE;
          end
        end
        default: begin
          sync_state <= CRVT_SYNC_IDLE;
        end
      endcase
    end
  end

  wire retrace_start = (sync_state == CRVT_SYNC_IDLE) && sync_begin;

  ////////////////////////////////////////////////////////////////////////////////
  // retrace interrupt flag, polled only
  // enable and clear
  wire irq_armed = !vsync_end_and_irq_ctl[CRVT_BIT_IRQ_DISABLE] &&
                   vsync_end_and_irq_ctl[CRVT_BIT_IRQ_CLEAR_N];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_pending <= 1'b0;
    end else if (!vsync_end_and_irq_ctl[CRVT_BIT_IRQ_CLEAR_N]) begin
      // clear bit held low keeps the flag down
      irq_pending <= 1'b0;
    end else if (retrace_start && irq_armed) begin
      irq_pending <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // double-buffered start address
  // arm on update bit in extended mode
  wire arm_update = wr_sa_low && ext_mode && io_wdata_in[CRVT_BIT_START_UPDATE];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      start_update <= 1'b0;
    end else if (arm_update) begin
      start_update <= 1'b1;
    end else if (retrace_start) begin
      start_update <= 1'b0;
    end
  end

  wire [CRVT_START_W-1:0] std_start = {4'h0, display_start_high, display_start_low};
  wire [CRVT_START_W-1:0] ext_start = {display_start_extension[3:0], display_start_high,
                                       display_start_low};

  logic [CRVT_START_W-1:0] next_start;
  // extended keeps the buffered value until the vsync-aligned load
  assign next_start = !ext_mode ? std_start :
                      (start_update && retrace_start) ? ext_start : start_addr_out;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      start_addr_out <= CRVT_RST_START;
    end else begin
      start_addr_out <= next_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path
  // update bit reads back pending
  wire [7:0] sa_low_read = ext_mode ?
      {start_update, display_start_low[6:0]} : display_start_low;

  logic [7:0] crtc_read;
  assign crtc_read =
      (crtc_index == CRVT_IDX_VERTICAL_OVERFLOW)  ? vertical_overflow :
      (crtc_index == CRVT_IDX_DISPLAY_START_HIGH) ? display_start_high :
      (crtc_index == CRVT_IDX_DISPLAY_START_LOW)  ? sa_low_read :
      (crtc_index == CRVT_IDX_CURSOR_LOCATION_HI) ? cursor_location_high :
      (crtc_index == CRVT_IDX_CURSOR_LOCATION_LO) ? cursor_location_low :
      (crtc_index == CRVT_IDX_VSYNC_START_LOW)    ? vsync_start_low :
      (crtc_index == CRVT_IDX_VSYNC_END_IRQ_CTL)  ? vsync_end_and_irq_ctl :
      (crtc_index == CRVT_IDX_VDISPLAY_END_LOW)   ? vdisplay_end_low :
      (crtc_index == CRVT_IDX_ROW_PITCH_LOW)      ? row_pitch_low :
      (crtc_index == CRVT_IDX_VDISPLAY_END_EXT)   ? vdisplay_end_extension :
      (crtc_index == CRVT_IDX_VSYNC_START_EXT)    ? vsync_start_extension :
      (crtc_index == CRVT_IDX_DISPLAY_START_EXT)  ? display_start_extension :
      CRVT_RST_BYTE;

  wire [7:0] ext_read = (ext_index == CRVT_IDX_IO_CONTROL) ? io_control : CRVT_RST_BYTE;

  // status bit 7 shows pending flag
  wire [7:0] status_read = {irq_pending, 7'h00};

  logic [7:0] next_rdata;
  assign next_rdata = crtc_idx_hit ? crtc_index :
                      crtc_dat_hit ? crtc_read :
                      ext_idx_hit  ? ext_index :
                      ext_dat_hit  ? ext_read :
                      status_hit   ? status_read :
                      CRVT_RST_BYTE;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      io_rdata_out <= CRVT_RST_BYTE;
    end else if (io_rd_in) begin
      io_rdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // display timing outputs
  // active through the last line inclusive
  wire next_vdisp = (next_line <= vde_value);

  wire [15:0] next_cursor = text_mode_in ? {cursor_location_high, cursor_location_low} :
                                           16'h0000;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vsync_out       <= 1'b0;
      vdisp_en_out    <= 1'b0;
      cursor_addr_out <= 16'h0000;
      cursor_en_out   <= 1'b0;
      ext_mode_out    <= 1'b0;
    end else begin
      vsync_out       <= (sync_state == CRVT_SYNC_ON);
      cursor_addr_out <= next_cursor;
      cursor_en_out   <= text_mode_in;
      ext_mode_out    <= ext_mode;
      if (frame_start_in || line_tick_in) begin
        vdisp_en_out <= next_vdisp;
      end
    end
  end

endmodule : crvt_top

/* File: hw/crvt_vsel.sv */
// composes a 10-bit or 12-bit vertical scan-line value from its pieces
`timescale 1ns/1ps
module crvt_vsel (
  input  wire logic                          ext_mode_in,
  input  wire logic [7:0]                    low_in,
  input  wire logic [3:0]                    ext_in,
  input  wire logic                          ovf_hi_in,
  input  wire logic                          ovf_lo_in,
  output logic      [crvt_pkg::CRVT_LINE_W-1:0] value_out
);
  import crvt_pkg::*;

  // standard mode takes two overflow bits, extended mode four extension bits
  assign value_out = ext_mode_in ? {ext_in, low_in} : {2'b00, ovf_hi_in, ovf_lo_in, low_in};

endmodule : crvt_vsel

/* File: include/crvt_pkg.sv */
// constants, offsets and types for the vertical timing and start address block
package crvt_pkg;

  // i/o port addresses of the indexed register files and the status port
  localparam logic [15:0] CRVT_IO_CRTC_IDX_MONO  = 16'h03B4;
  localparam logic [15:0] CRVT_IO_CRTC_DAT_MONO  = 16'h03B5;
  localparam logic [15:0] CRVT_IO_CRTC_IDX_COLOR = 16'h03D4;
  localparam logic [15:0] CRVT_IO_CRTC_DAT_COLOR = 16'h03D5;
  localparam logic [15:0] CRVT_IO_EXT_IDX        = 16'h03D6;
  localparam logic [15:0] CRVT_IO_EXT_DAT        = 16'h03D7;
  localparam logic [15:0] CRVT_IO_STATUS_ZERO    = 16'h03C2;

  // crtc register indexes
  localparam logic [7:0] CRVT_IDX_VERTICAL_OVERFLOW   = 8'h07;
  localparam logic [7:0] CRVT_IDX_PROTECT_LAST        = 8'h07;
  localparam logic [7:0] CRVT_IDX_DISPLAY_START_HIGH  = 8'h0C;
  localparam logic [7:0] CRVT_IDX_DISPLAY_START_LOW   = 8'h0D;
  localparam logic [7:0] CRVT_IDX_CURSOR_LOCATION_HI  = 8'h0E;
  localparam logic [7:0] CRVT_IDX_CURSOR_LOCATION_LO  = 8'h0F;
  localparam logic [7:0] CRVT_IDX_VSYNC_START_LOW     = 8'h10;
  localparam logic [7:0] CRVT_IDX_VSYNC_END_IRQ_CTL   = 8'h11;
  localparam logic [7:0] CRVT_IDX_VDISPLAY_END_LOW    = 8'h12;
  localparam logic [7:0] CRVT_IDX_ROW_PITCH_LOW       = 8'h13;
  localparam logic [7:0] CRVT_IDX_VDISPLAY_END_EXT    = 8'h31;
  localparam logic [7:0] CRVT_IDX_VSYNC_START_EXT     = 8'h32;
  localparam logic [7:0] CRVT_IDX_DISPLAY_START_EXT   = 8'h40;
  // extension register index
  localparam logic [7:0] CRVT_IDX_IO_CONTROL          = 8'h09;

  // field positions
  localparam int CRVT_BIT_MODE_EXT      = 0;
  localparam int CRVT_BIT_START_UPDATE  = 7;
  localparam int CRVT_BIT_PROTECT       = 7;
  localparam int CRVT_BIT_RESERVED      = 6;
  localparam int CRVT_BIT_IRQ_DISABLE   = 5;
  localparam int CRVT_BIT_IRQ_CLEAR_N   = 4;
  localparam int CRVT_BIT_OVF_ALWAYS_WR = 4;
  localparam int CRVT_BIT_OVF_VSS9      = 7;
  localparam int CRVT_BIT_OVF_VSS8      = 2;
  localparam int CRVT_BIT_OVF_VDE9      = 6;
  localparam int CRVT_BIT_OVF_VDE8      = 1;
  localparam int CRVT_BIT_STATUS_IRQ    = 7;

  // values after reset
  localparam logic [7:0]  CRVT_RST_BYTE  = 8'h00;
  localparam logic [11:0] CRVT_RST_LINE  = 12'h000;
  localparam logic [19:0] CRVT_RST_START = 20'h00000;

  // widths
  localparam int CRVT_LINE_W  = 12;
  localparam int CRVT_START_W = 20;

  // vertical sync state
  typedef enum logic [0:0] {
    CRVT_SYNC_IDLE = 1'b0,
    CRVT_SYNC_ON   = 1'b1
  } crvt_sync_t;

endpackage : crvt_pkg

/* File: testbench/crvt_display_model.sv */
// display-side model: measures sync pulse and active area in scan lines
`timescale 1ns/1ps
module crvt_display_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        line_tick_in,
  input  wire logic        vsync_in,
  input  wire logic        vdisp_en_in,
  output logic      [11:0] sync_len_out,
  output logic      [11:0] active_len_out
);
  logic        vsync_q;
  logic        vdisp_q;
  logic [11:0] sync_cnt;
  logic [11:0] active_cnt;
  // counts latch on the falling level, so a pulse is reported only once it ends
  always_ff @(posedge clk_in) begin
    vsync_q <= vsync_in;
    vdisp_q <= vdisp_en_in;
    if (!rst_n_in) begin
      sync_cnt       <= 12'h000;
      active_cnt     <= 12'h000;
      sync_len_out   <= 12'h000;
      active_len_out <= 12'h000;
    end else begin
      if (vsync_q && !vsync_in) begin
        sync_len_out <= sync_cnt;
        sync_cnt     <= 12'h000;
      end else if (line_tick_in && vsync_in) begin
        sync_cnt <= sync_cnt + 12'h001;
      end
      if (vdisp_q && !vdisp_en_in) begin
        active_len_out <= active_cnt;
        active_cnt     <= 12'h000;
      end else if (line_tick_in && vdisp_en_in) begin
        active_cnt <= active_cnt + 12'h001;
      end
    end
  end
endmodule : crvt_display_model

/* File: testbench/crvt_top_properties.sv */
// assertion checker for the vertical timing block
`timescale 1ns/1ps
module crvt_top_properties
  import crvt_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] io_addr_in,
  input wire logic        io_wr_in,
  input wire logic        io_rd_in,
  input wire logic [7:0]  io_wdata_in,
  input wire logic        line_tick_in,
  input wire logic        frame_start_in,
  input wire logic        text_mode_in,
  input wire logic [7:0]  io_rdata_out,
  input wire logic        vsync_out,
  input wire logic        vdisp_en_out,
  input wire logic [19:0] start_addr_out,
  input wire logic [15:0] cursor_addr_out,
  input wire logic        cursor_en_out,
  input wire logic        ext_mode_out
);
  logic [7:0] crtc_idx;
  logic [7:0] ext_idx;
  logic       irq_clr_n;
  logic       wr_crtc;
  logic       rd_crtc;
  logic       wr_ext;
  logic       tick;
  assign wr_crtc = io_wr_in && (io_addr_in == CRVT_IO_CRTC_DAT_MONO
                   || io_addr_in == CRVT_IO_CRTC_DAT_COLOR);
  assign rd_crtc = io_rd_in && (io_addr_in == CRVT_IO_CRTC_DAT_MONO
                   || io_addr_in == CRVT_IO_CRTC_DAT_COLOR);
  assign wr_ext = io_wr_in && io_addr_in == CRVT_IO_EXT_DAT;
  assign tick = line_tick_in || frame_start_in;
  ////////////////////////////////////////////////////////////////////////////////////////
  // mirror of the index latches, so data writes can be decoded here
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      crtc_idx  <= 8'h00;
      ext_idx   <= 8'h00;
      irq_clr_n <= 1'b0;
    end else begin
      if (io_wr_in && (io_addr_in == CRVT_IO_CRTC_IDX_MONO
          || io_addr_in == CRVT_IO_CRTC_IDX_COLOR)) crtc_idx <= io_wdata_in;
      if (io_wr_in && io_addr_in == CRVT_IO_EXT_IDX) ext_idx <= io_wdata_in;
      if (wr_crtc && crtc_idx == CRVT_IDX_VSYNC_END_IRQ_CTL) begin
        irq_clr_n <= io_wdata_in[CRVT_BIT_IRQ_CLEAR_N];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_sync_rise_tick: assert property (
    $rose(vsync_out) |-> $past(tick, 2)) else $error("vsync rose without a line tick");
  a_sync_fall_tick: assert property (
    $fell(vsync_out) |-> $past(tick, 2)) else $error("vsync fell without a line tick");
  a_cursor_gfx_zero: assert property (
    !cursor_en_out |-> cursor_addr_out == 16'h0000) else $error("cursor shown in graphics");
  a_cursor_hi_load: assert property (
    wr_crtc && crtc_idx == CRVT_IDX_CURSOR_LOCATION_HI && text_mode_in
    |-> ##2 (!cursor_en_out || cursor_addr_out[15:8] == $past(io_wdata_in, 2)))
    else $error("cursor high byte not applied");
  a_start_std_low: assert property (
    wr_crtc && crtc_idx == CRVT_IDX_DISPLAY_START_LOW && !ext_mode_out
    |-> ##2 (ext_mode_out || start_addr_out[7:0] == $past(io_wdata_in, 2)))
    else $error("standard start low byte not applied");
  a_start_ext_vsync: assert property (
    ext_mode_out && $past(ext_mode_out) && $changed(start_addr_out) |=> $rose(vsync_out))
    else $error("extended start changed away from retrace start");
  a_mode_follows: assert property (
    wr_ext && ext_idx == CRVT_IDX_IO_CONTROL
    |-> ##2 ext_mode_out == $past(io_wdata_in[CRVT_BIT_MODE_EXT], 2))
    else $error("mode bit not applied");
  a_reserved_bit_zero: assert property (
    rd_crtc && crtc_idx == CRVT_IDX_VSYNC_END_IRQ_CTL |=> !io_rdata_out[CRVT_BIT_RESERVED])
    else $error("reserved sync end bit read as one");
  a_irq_clear_wins: assert property (
    io_rd_in && io_addr_in == CRVT_IO_STATUS_ZERO && !irq_clr_n
    |=> !io_rdata_out[CRVT_BIT_STATUS_IRQ]) else $error("interrupt pending while cleared");

  c_sync_pulse: cover property ($rose(vsync_out));
  c_ext_load: cover property (ext_mode_out && $changed(start_addr_out));
  c_irq_seen: cover property (io_rd_in && io_addr_in == CRVT_IO_STATUS_ZERO
    ##1 io_rdata_out[CRVT_BIT_STATUS_IRQ]);
endmodule : crvt_top_properties

bind crvt_top crvt_top_properties u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
  .io_wdata_in(io_wdata_in), .line_tick_in(line_tick_in), .frame_start_in(frame_start_in),
  .text_mode_in(text_mode_in), .io_rdata_out(io_rdata_out), .vsync_out(vsync_out),
  .vdisp_en_out(vdisp_en_out), .start_addr_out(start_addr_out),
  .cursor_addr_out(cursor_addr_out), .cursor_en_out(cursor_en_out),
  .ext_mode_out(ext_mode_out));

/* File: testbench/tb_crvt_top.sv */
// self-checking bench for the vertical timing block
`timescale 1ns/1ps
module tb_crvt_top;
  import crvt_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [15:0] io_addr_in = 16'h0000;
  logic        io_wr_in = 1'b0;
  logic        io_rd_in = 1'b0;
  logic [7:0]  io_wdata_in = 8'h00;
  logic        line_tick_in = 1'b0;
  logic        frame_start_in = 1'b0;
  logic        text_mode_in = 1'b0;
  logic [7:0]  io_rdata_out;
  logic        vsync_out;
  logic        vdisp_en_out;
  logic [19:0] start_addr_out;
  logic [15:0] cursor_addr_out;
  logic        cursor_en_out;
  logic        ext_mode_out;
  logic [11:0] sync_len;
  logic [11:0] active_len;
  logic [7:0]  rv;
  int          errors = 0;
  int          check_count = 0;
  int          line_no = 0;
  int          first_sync = -1;

  always #20 clk_in = ~clk_in;

  crvt_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
    .line_tick_in(line_tick_in), .frame_start_in(frame_start_in),
    .text_mode_in(text_mode_in), .io_rdata_out(io_rdata_out), .vsync_out(vsync_out),
    .vdisp_en_out(vdisp_en_out), .start_addr_out(start_addr_out),
    .cursor_addr_out(cursor_addr_out), .cursor_en_out(cursor_en_out),
    .ext_mode_out(ext_mode_out));
  crvt_display_model u_display (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .line_tick_in(line_tick_in), .vsync_in(vsync_out), .vdisp_en_in(vdisp_en_out),
    .sync_len_out(sync_len), .active_len_out(active_len));
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // one strobe then an idle cycle, so back-to-back calls never re-assign in one step
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    @(posedge clk_in);
    #1 io_wr_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : io_wr

  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    io_addr_in = a;
    io_rd_in = 1'b1;
    @(posedge clk_in);
    #1 io_rd_in = 1'b0;
    d = io_rdata_out;
    @(posedge clk_in);
    #1;
  endtask : io_rd

  task automatic crtc_wr(input logic [7:0] idx, input logic [7:0] d);
    io_wr(CRVT_IO_CRTC_IDX_COLOR, idx);
    io_wr(CRVT_IO_CRTC_DAT_COLOR, d);
  endtask : crtc_wr

  task automatic crtc_rd(input logic [7:0] idx, output logic [7:0] d);
    io_wr(CRVT_IO_CRTC_IDX_MONO, idx);
    io_rd(CRVT_IO_CRTC_DAT_MONO, d);
  endtask : crtc_rd

  // ticks four cycles apart leave room for the two-edge sync delay
  task automatic lines(input int n);
    repeat (n) begin
      line_tick_in = 1'b1;
      @(posedge clk_in);
      #1 line_tick_in = 1'b0;
      line_no++;
      repeat (3) @(posedge clk_in);
      #1;
      if (vsync_out === 1'b1 && first_sync < 0) first_sync = line_no;
    end
  endtask : lines

  task automatic frame;
    frame_start_in = 1'b1;
    @(posedge clk_in);
    #1 frame_start_in = 1'b0;
    line_no = 0;
    first_sync = -1;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 12; i < 20; i++) begin
      crtc_rd(8'(i), rv);
      check("reset value", 20'(rv), 20'h00000);
    end
    io_rd(16'h03C0, rv);
    check("unmapped port", 20'(rv), 20'h00000);
    crtc_wr(CRVT_IDX_VSYNC_END_IRQ_CTL, 8'hFF);
    crtc_rd(CRVT_IDX_VSYNC_END_IRQ_CTL, rv);
    check("sync end", 20'(rv), 20'h000BF);
    crtc_wr(CRVT_IDX_VERTICAL_OVERFLOW, 8'hFF);
    crtc_rd(CRVT_IDX_VERTICAL_OVERFLOW, rv);
    check("protected overflow", 20'(rv), 20'h00010);
    // end nibble is start 105h plus three lines
    crtc_wr(CRVT_IDX_VSYNC_END_IRQ_CTL, 8'h18);
    crtc_wr(CRVT_IDX_VERTICAL_OVERFLOW, 8'h06);
    crtc_rd(CRVT_IDX_VERTICAL_OVERFLOW, rv);
    check("open overflow", 20'(rv), 20'h00006);
    crtc_wr(CRVT_IDX_DISPLAY_START_HIGH, 8'h12);
    crtc_wr(CRVT_IDX_DISPLAY_START_LOW, 8'h34);
    crtc_wr(CRVT_IDX_DISPLAY_START_EXT, 8'h05);
    check("standard start", start_addr_out, 20'h01234);
    text_mode_in = 1'b1;
    crtc_wr(CRVT_IDX_CURSOR_LOCATION_HI, 8'hAB);
    crtc_wr(CRVT_IDX_CURSOR_LOCATION_LO, 8'hCD);
    check("text cursor", 20'(cursor_addr_out), 20'h0ABCD);
    text_mode_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check("graphics cursor", 20'(cursor_addr_out), 20'h00000);
    crtc_wr(CRVT_IDX_VSYNC_START_LOW, 8'h05);
    crtc_wr(CRVT_IDX_VDISPLAY_END_LOW, 8'h03);
    frame();
    lines(16'h0110);
    check("std sync line", 20'(first_sync), 20'h00105);
    check("std sync length", 20'(sync_len), 20'h00003);
    check("std active lines", 20'(active_len), 20'h00104);
    io_rd(CRVT_IO_STATUS_ZERO, rv);
    check("irq pending", 20'(rv[7]), 20'h00001);
    // clear bit written low, then the flag reads back as zero
    crtc_wr(CRVT_IDX_VSYNC_END_IRQ_CTL, 8'h08);
    io_rd(CRVT_IO_STATUS_ZERO, rv);
    check("irq cleared", 20'(rv[7]), 20'h00000);
    io_wr(CRVT_IO_EXT_IDX, CRVT_IDX_IO_CONTROL);
    io_wr(CRVT_IO_EXT_DAT, 8'h01);
    check("mode", 20'(ext_mode_out), 20'h00001);
    crtc_wr(CRVT_IDX_DISPLAY_START_EXT, 8'h0A);
    crtc_wr(CRVT_IDX_DISPLAY_START_HIGH, 8'h56);
    crtc_wr(CRVT_IDX_DISPLAY_START_LOW, 8'h78);
    // update bit set only after all three bytes
    crtc_wr(CRVT_IDX_DISPLAY_START_LOW, 8'hF8);
    crtc_rd(CRVT_IDX_DISPLAY_START_LOW, rv);
    check("update armed", 20'(rv), 20'h000F8);
    crtc_wr(CRVT_IDX_VSYNC_START_EXT, 8'h02);
    crtc_wr(CRVT_IDX_VSYNC_START_LOW, 8'h10);
    crtc_wr(CRVT_IDX_VDISPLAY_END_EXT, 8'h00);
    crtc_wr(CRVT_IDX_VDISPLAY_END_LOW, 8'hF0);
    // end nibble is start 210h plus two; interrupt masked
    crtc_wr(CRVT_IDX_VSYNC_END_IRQ_CTL, 8'h32);
    frame();
    lines(16'h0100);
    crtc_rd(CRVT_IDX_DISPLAY_START_LOW, rv);
    check("update pending", 20'(rv), 20'h000F8);
    lines(16'h0118);
    check("ext sync line", 20'(first_sync), 20'h00210);
    check("ext sync length", 20'(sync_len), 20'h00002);
    check("ext active lines", 20'(active_len), 20'h000F1);
    check("ext start", start_addr_out, 20'hA56F8);
    crtc_rd(CRVT_IDX_DISPLAY_START_LOW, rv);
    check("update done", 20'(rv), 20'h00078);
    io_rd(CRVT_IO_STATUS_ZERO, rv);
    check("irq masked", 20'(rv[7]), 20'h00000);
    test_done();
  end
endmodule : tb_crvt_top
